/* hdl/ctic_trap_ctrl.sv */
`timescale 1ns/100ps
module ctic_trap_ctrl
  import ctic_pkg::*;
#(
  parameter int ADDR_BITS = ctic_pkg::ADDR_W
)(
  input  wire logic                     i_mclk,
  input  wire logic                     i_reset,
  // decode / execute side
  input  wire logic                     i_instr_start,
  input  wire ctic_pkg::ctic_iclass_t   i_instr_class,
  input  wire logic [ADDR_BITS-1:0]     i_instr_addr,
  input  wire logic [ADDR_BITS-1:0]     i_next_addr,
  input  wire logic                     i_privileged,
  input  wire logic                     i_iter_done,
  input  wire logic                     i_block_last,
  input  wire logic                     i_instr_done,
  input  wire logic                     i_div_zero,
  input  wire logic                     i_div_ovf,
  input  wire logic [ADDR_BITS-1:0]     i_ext_src_addr,
  input  wire logic [ADDR_BITS-1:0]     i_ext_dst_addr,
  input  wire logic                     i_push_valid,
  input  wire logic [ADDR_BITS-1:0]     i_sp_after_push,
  input  wire logic                     i_user_xfer_ok,
  // mmu
  input  wire logic                     i_mmu_violation,
  input  wire logic [ADDR_BITS-1:0]     i_mmu_fault_addr,
  // control bits
  input  wire logic                     i_user_mode,
  input  wire logic                     i_ext_arch_enable,
  input  wire logic                     i_single_step,
  input  wire logic                     i_bp_on_halt,
  input  wire logic [ADDR_BITS-1:0]     i_stack_limit,
  input  wire logic [15:0]              i_msr,
  input  wire logic [7:0]               i_trap_mask,
  // interrupt request from peripherals (asynchronous pin)
  input  wire logic                     i_irq,
  input  wire logic                     i_irq_enable,
  // outputs
  output logic                          o_hold_instr,
  output logic                          o_abort,
  output logic                          o_commit,
  output logic                          o_push_valid,
  output logic [ADDR_BITS-1:0]          o_push_data,
  output logic                          o_vector_take,
  output logic [3:0]                    o_vector_cause,
  output logic [1:0]                    o_vector_mode,
  output logic                          o_enter_system,
  output logic [ADDR_BITS-1:0]          o_fault_page,
  output logic                          o_flag_write,
  output logic                          o_flag_ok,
  output logic [7:0]                    o_trap_pending
);
  import ctic_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    ctic_state_t            st;
    logic                   irq_s1;
    logic                   irq_s2;
    logic [NUM_TRAPS-1:0]   pend;
    logic [3:0]             cause;
    logic                   is_irq;
    logic [ADDR_BITS-1:0]   ret_addr;
    logic [ADDR_BITS-1:0]   op_a;
    logic [ADDR_BITS-1:0]   op_b;
    logic [15:0]            msr_save;
    logic                   ext_push;
    logic [ADDR_BITS-1:0]   fault_page;
    logic                   flag_write;
    logic                   flag_ok;
    ctic_iclass_t           cls;
    logic [ADDR_BITS-1:0]   cur_addr;
    logic [ADDR_BITS-1:0]   nxt_addr;
  } ctic_st_t;

  ctic_st_t s_reg;
  ctic_st_t s_next;

  logic [NUM_TRAPS-1:0] raise;
  logic [NUM_TRAPS-1:0] eligible;
  logic [3:0]           sel;
  logic                 stk_hit;
  logic                 irq_live;
  logic                 at_boundary;
  logic                 block_break;

  // ****************************************************************
  // trap detection
  // ****************************************************************
  always_comb
  begin
    raise   = '0;
    stk_hit = (i_sp_after_push[ADDR_BITS-1:STK_REGION_SHIFT] ==
               i_stack_limit[ADDR_BITS-1:STK_REGION_SHIFT]);
    if (s_reg.st == ST_EXEC)
    begin
      raise[TR_DIV]  = (s_reg.cls == IC_DIVIDE) &&
                       (i_div_zero || i_div_ovf);                 // [RULE8]
      raise[TR_ACCV] = i_mmu_violation;                           // [RULE14]
      // push is the only word load able to trap; others never do
      raise[TR_STKW] = i_push_valid && stk_hit;            // [RULE16] [RULE21]
      raise[TR_SSTEP] = i_single_step && i_instr_done;     // [RULE17] [RULE22]
    end
    if (i_instr_start && s_reg.st == ST_IDLE)
    begin
      raise[TR_EXT]  = (i_instr_class == IC_EXTENDED) &&
                       !i_ext_arch_enable;                        // [RULE9]
      raise[TR_PRIV] = i_user_mode && (i_privileged ||
                       i_instr_class == IC_USER_LOAD);      // [RULE12] [RULE19]
      raise[TR_SC]   = (i_instr_class == IC_SYSCALL);             // [RULE13]
      raise[TR_BPH]  = (i_instr_class == IC_HALT) && i_bp_on_halt; // [RULE18]
    end
  end

  // non-maskable classes ignore the mask  [RULE6] [RULE7]
  assign eligible = (s_reg.pend | raise) &
                    (~MASKABLE_TRAPS | i_trap_mask);

  always_comb
  begin
    sel = NO_TRAP;
    for (int k = NUM_TRAPS - 1; k >= 0; k--)
    begin
      if (eligible[k])
      begin
        sel = 4'(k);
      end
    end
  end

  assign irq_live    = s_reg.irq_s2 && i_irq_enable;
  assign at_boundary = (s_reg.st == ST_EXEC) && i_instr_done;
  assign block_break = (s_reg.st == ST_EXEC) && (s_reg.cls == IC_BLOCK) &&
                       i_iter_done && !i_block_last;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb
  begin
    s_next            = s_reg;
    s_next.irq_s1     = i_irq;
    s_next.irq_s2     = s_reg.irq_s1;
    s_next.flag_write = 1'b0;
    s_next.pend       = s_reg.pend | raise;
    unique case (s_reg.st)
      ST_IDLE:
      begin
        if (i_instr_start)
        begin
          s_next.cls      = i_instr_class;
          s_next.cur_addr = i_instr_addr;
          s_next.nxt_addr = i_next_addr;
          s_next.op_a     = i_ext_src_addr;
          s_next.op_b     = i_ext_dst_addr;
          s_next.st       = ST_EXEC;
          // a masked decode trap lets the instruction run instead
          if (|(raise & eligible))
          begin
            // instruction is not performed; the trap saves its address, or the next address for a system call
            s_next.cause    = sel;
            s_next.is_irq   = 1'b0;
            s_next.ret_addr = (sel == TR_SC) ? i_next_addr : i_instr_addr;
            s_next.ext_push = (sel == TR_EXT);
            s_next.msr_save = i_msr;
            s_next.pend[sel[2:0]] = 1'b0;
            s_next.st       = ST_PUSH_A;
          end
        end
      end
      ST_EXEC:
      begin
        if (eligible[TR_ACCV])
        begin
          // abort, registers untouched: resume at the instruction
          s_next.fault_page = i_mmu_fault_addr;                   // [RULE14]
          s_next.ret_addr   = s_reg.cur_addr;                     // [RULE15]
          s_next.cause      = 4'(TR_ACCV);
          s_next.is_irq     = 1'b0;
          s_next.ext_push   = 1'b0;
          s_next.msr_save   = i_msr;
          s_next.pend[TR_ACCV] = 1'b0;
          s_next.st         = ST_PUSH_A;
        end
        else if (block_break && irq_live)
        begin
          s_next.ret_addr = s_reg.cur_addr; // [RULE2] [RULE3] [RULE4]
          s_next.is_irq   = 1'b1;
          s_next.ext_push = 1'b0;
          s_next.msr_save = i_msr;
          s_next.st       = ST_PUSH_A;
        end
        else if (at_boundary)
        begin
          if (s_reg.cls == IC_USER_LOAD)
          begin
            s_next.flag_write = 1'b1;                             // [RULE19]
            s_next.flag_ok    = i_user_xfer_ok;
          end
          s_next.ret_addr = s_reg.nxt_addr;                       // [RULE22]
          s_next.msr_save = i_msr;
          s_next.ext_push = 1'b0;
          if (sel != NO_TRAP)
          begin
            s_next.cause    = sel;
            s_next.is_irq   = 1'b0;
            s_next.pend[sel[2:0]] = 1'b0;
            s_next.st       = ST_PUSH_A;
          end
          else if (irq_live)
          begin
            s_next.is_irq = 1'b1;                                 // [RULE1]
            s_next.st     = ST_PUSH_A;
          end
          else
          begin
            s_next.st = ST_IDLE;
          end
        end
      end
      ST_PUSH_A:
      begin
        s_next.st = s_reg.ext_push ? ST_PUSH_B : ST_PUSH_C;
      end
      ST_PUSH_B:
      begin
        s_next.st = ST_PUSH_C;
      end
      ST_PUSH_C:
      begin
        s_next.st = ST_VECTOR;
      end
      ST_VECTOR:
      begin
        s_next.st = ST_IDLE;
      end
      default:
      begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // stack image: msr then return address; for the extended trap msr, then the
  // destination then source address instead, so a handler pops them in use order
  always_comb
  begin
    o_push_valid = 1'b1;
    o_push_data  = '0;
    unique case (s_reg.st)
      ST_PUSH_A: o_push_data = s_reg.msr_save[ADDR_BITS-1:0];
      ST_PUSH_B: o_push_data = s_reg.op_b;                        // [RULE11]
      ST_PUSH_C: o_push_data = s_reg.ext_push ? s_reg.op_a : s_reg.ret_addr;
      default:   o_push_valid = 1'b0;
    endcase
  end

  assign o_hold_instr   = (s_reg.st != ST_IDLE) && (s_reg.st != ST_EXEC);
  assign o_abort        = (s_reg.st == ST_EXEC) && eligible[TR_ACCV];
  // other byte and word loads simply commit; flags are never touched
  assign o_commit       = at_boundary && !eligible[TR_ACCV]; // [RULE20] [RULE21]
  assign o_vector_take  = (s_reg.st == ST_VECTOR);
  assign o_vector_cause = s_reg.is_irq ? NO_TRAP : s_reg.cause;
  assign o_vector_mode  = TRAP_INT_MODE;                          // [RULE5]
  assign o_enter_system = (s_reg.st == ST_VECTOR) && !s_reg.is_irq;
  assign o_fault_page   = s_reg.fault_page;
  assign o_flag_write   = s_reg.flag_write;
  assign o_flag_ok      = s_reg.flag_ok;
  assign o_trap_pending = s_reg.pend;

endmodule // ctic_trap_ctrl

/* hdl/ctic_pkg.sv */
// Overview of operation
// RULE1: enabled interrupt is serviced only once the current instruction completes.
// RULE2: interrupt during a repeating block instruction suspends it after this iteration.
// RULE3: suspended block instruction saves its own address for re-execution.
// RULE4: counter and pointers after each iteration allow a clean reissue.
// RULE5: every trap is entered like a mode 3 vectored interrupt.
// RULE6: only extended, stack warning, single step, halt breakpoint traps are maskable.
// RULE7: eight trap classes are detected.
// RULE8: divide traps on zero divisor or unrepresentable quotient.
// RULE9: extended instruction with ext_arch_enable clear raises the extended trap.
// RULE10: software clears ext_arch_enable without coprocessor_unit or on 8-bit bus.
// RULE11: extended trap pushes operand addresses in reverse order of use.
// RULE12: privileged instruction in user mode traps instead of executing.
// RULE13: system call always traps into system mode.
// RULE14: access violation aborts, pushes address and status, latches fault page.
// RULE15: after access violation registers hold pre-instruction or pre-iteration values.
// RULE16: push reaching the configured 16-byte stack region raises stack warning.
// RULE17: single-step bit set traps after every executed instruction.
// RULE18: halt with breakpoint-on-halt bit set raises that trap.
// RULE19: user space loads are privileged and report success in the flags.
// RULE20: other byte loads and exchanges leave flags and never except.
// RULE21: word loads keep flags except alternate exchange; only push may trap.
// RULE22: single-step trap taken after completion, saving the next address.
//
package ctic_pkg;

  // ****************************************************************
  // trap classes, also the bit index of each trap in vectors
  // ****************************************************************
  localparam int NUM_TRAPS = 8;
  localparam int TR_DIV    = 0;
  localparam int TR_EXT    = 1;
  localparam int TR_PRIV   = 2;
  localparam int TR_SC     = 3;
  localparam int TR_ACCV   = 4;
  localparam int TR_STKW   = 5;
  localparam int TR_SSTEP  = 6;
  localparam int TR_BPH    = 7;

  localparam logic [7:0] MASKABLE_TRAPS = 8'hE2;
  localparam logic [3:0] NO_TRAP        = 4'hF;

  localparam int          ADDR_W      = 16;
  localparam int          STK_REGION_SHIFT = 4;
  localparam logic [1:0]  TRAP_INT_MODE = 2'h3;

  // ****************************************************************
  // instruction classes presented by the decoder
  // ****************************************************************
  typedef enum logic [3:0] {
    IC_PLAIN     = 4'h0,
    IC_DIVIDE    = 4'h1,
    IC_EXTENDED  = 4'h2,
    IC_SYSCALL   = 4'h3,
    IC_HALT      = 4'h4,
    IC_BLOCK     = 4'h5,
    IC_USER_LOAD = 4'h6,
    IC_BYTE_LOAD = 4'h7,
    IC_WORD_LOAD = 4'h8,
    IC_PUSH      = 4'h9,
    IC_EX_AF     = 4'hA
  } ctic_iclass_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_EXEC    = 3'h1,
    ST_PUSH_A  = 3'h2,
    ST_PUSH_B  = 3'h3,
    ST_PUSH_C  = 3'h4,
    ST_VECTOR  = 3'h5
  } ctic_state_t;

endpackage : ctic_pkg

/* tb/ctic_periph.sv */
`timescale 1ns/100ps
module ctic_periph
(
  input  wire logic i_mclk,
  input  wire logic i_reset,
  input  wire logic i_raise,
  input  wire logic i_ack,
  output logic      o_irq
);
  // ****************************************************************
  // request line of one peripheral
  // ****************************************************************
  // the request stays up until serviced, so a late boundary still sees it
  always_ff @(posedge i_mclk or posedge i_reset)
    if (i_reset)
      o_irq <= 1'b0;
    else if (i_raise)
      o_irq <= 1'b1;
    else if (i_ack)
      o_irq <= 1'b0;
endmodule // ctic_periph

/* tb/ctic_trap_sva.sv */
`timescale 1ns/100ps
module ctic_trap_sva
  import ctic_pkg::*;
#(
  parameter int ADDR_BITS = 16
)(
  input wire logic                   i_mclk,
  input wire logic                   i_reset,
  input wire logic                   i_instr_start,
  input wire ctic_pkg::ctic_iclass_t i_instr_class,
  input wire logic [ADDR_BITS-1:0]   i_instr_addr,
  input wire logic [ADDR_BITS-1:0]   i_next_addr,
  input wire logic                   i_privileged,
  input wire logic                   i_user_mode,
  input wire logic                   i_instr_done,
  input wire logic                   i_mmu_violation,
  input wire logic                   i_single_step,
  input wire logic [15:0]            i_msr,
  input wire logic [7:0]             i_trap_mask,
  input wire logic                   i_user_xfer_ok,
  input wire logic                   o_abort,
  input wire logic                   o_commit,
  input wire logic                   o_push_valid,
  input wire logic [ADDR_BITS-1:0]   o_push_data,
  input wire logic                   o_vector_take,
  input wire logic [3:0]             o_vector_cause,
  input wire logic [1:0]             o_vector_mode,
  input wire logic                   o_enter_system,
  input wire logic                   o_flag_write,
  input wire logic                   o_flag_ok
);
  // ****************************************************************
  // shadow of the issued instruction
  // ****************************************************************
  logic [ADDR_BITS-1:0] addr_reg, next_reg;
  logic [3:0]           cls_reg;
  always_ff @(posedge i_mclk or posedge i_reset)
    if (i_reset)
      {cls_reg, addr_reg, next_reg} <= '0;
    else if (i_instr_start)
      {cls_reg, addr_reg, next_reg} <= {i_instr_class, i_instr_addr,
                                        i_next_addr};

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  mode_fixed_a: assert property (o_vector_mode == TRAP_INT_MODE)
    else $error("vector mode is not three");
  vec_after_push_a: assert property (o_vector_take |-> $past(o_push_valid))
    else $error("vector taken without stacked state");
  syscall_seq_a: assert property (i_instr_start &&
    i_instr_class == IC_SYSCALL && !(i_privileged && i_user_mode)
    |=> o_push_valid && o_push_data == i_msr ##1 o_push_data == next_reg
    ##1 o_vector_take && o_vector_cause == 4'h3 && o_enter_system)
    else $error("system call entry wrong");
  priv_trap_a: assert property (i_instr_start && i_privileged &&
    i_user_mode && i_instr_class != IC_EXTENDED
    |-> ##3 o_vector_take && o_vector_cause == 4'h2)
    else $error("privileged opcode in user mode not trapped");
  abort_seq_a: assert property (i_mmu_violation |-> o_abort &&
    !o_commit ##1 o_push_data == i_msr ##1 o_push_data == addr_reg)
    else $error("access violation entry wrong");
  step_seq_a: assert property (i_instr_done && i_single_step &&
    i_trap_mask[TR_SSTEP] && !i_mmu_violation |=> o_push_data == i_msr
    ##1 o_push_data == next_reg ##1 o_vector_take && o_vector_cause == 4'h6)
    else $error("single step entry wrong");
  mask_kept_a: assert property (o_vector_take && o_vector_cause != 4'hF
    && MASKABLE_TRAPS[o_vector_cause[2:0]] |-> i_trap_mask[o_vector_cause[2:0]])
    else $error("masked trap was taken");
  flag_report_a: assert property (o_commit && cls_reg == IC_USER_LOAD
    |=> o_flag_write && o_flag_ok == $past(i_user_xfer_ok))
    else $error("user space load flag wrong");
  flag_keep_a: assert property (o_flag_write |-> $past(cls_reg) == IC_USER_LOAD)
    else $error("flags written by other load");
endmodule // ctic_trap_sva

bind ctic_trap_ctrl ctic_trap_sva #(.ADDR_BITS(ADDR_BITS)) u_sva (.i_mclk,
  .i_reset, .i_instr_start, .i_instr_class, .i_instr_addr, .i_next_addr,
  .i_privileged, .i_user_mode, .i_instr_done, .i_mmu_violation,
  .i_single_step, .i_msr, .i_trap_mask, .i_user_xfer_ok, .o_abort, .o_commit,
  .o_push_valid, .o_push_data, .o_vector_take, .o_vector_cause,
  .o_vector_mode, .o_enter_system, .o_flag_write, .o_flag_ok);

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import ctic_pkg::*;
  typedef struct {
    ctic_iclass_t cls;
    logic pv, um, ext, bp, ss, dz, ov;
    logic [1:0] ev;
    logic vec;
    logic [7:0] msk;
    logic [3:0] cause;
    logic [1:0] rs;
  } ctic_row_t;
  logic i_mclk, i_reset, i_instr_start, i_privileged, i_iter_done;
  logic i_block_last, i_instr_done, i_div_zero, i_div_ovf, i_push_valid;
  logic i_user_xfer_ok, i_mmu_violation, i_user_mode, i_ext_arch_enable;
  logic i_single_step, i_bp_on_halt, i_irq, i_irq_enable, raise;
  ctic_iclass_t i_instr_class;
  logic [15:0] i_instr_addr, i_next_addr, i_ext_src_addr, i_ext_dst_addr;
  logic [15:0] i_sp_after_push, i_mmu_fault_addr, i_stack_limit, i_msr;
  logic [15:0] o_push_data, o_fault_page;
  logic [7:0] i_trap_mask, o_trap_pending;
  logic o_hold_instr, o_abort, o_commit, o_push_valid, o_vector_take;
  logic o_enter_system, o_flag_write, o_flag_ok;
  logic [3:0] o_vector_cause;
  logic [1:0] o_vector_mode;
  int err_count, n_tests;
  // ev: 0 done, 1 iteration, 2 mmu fault, 3 push then done
  ctic_row_t rows[17] = '{
    '{IC_SYSCALL,  0,0,1,0,0,0,0,0,1,8'hFF,4'h3,1},
    '{IC_PLAIN,    1,1,1,0,0,0,0,0,1,8'hFF,4'h2,0},
    '{IC_USER_LOAD,1,1,1,0,0,0,0,0,1,8'hFF,4'h2,0},
    '{IC_USER_LOAD,1,0,1,0,0,0,0,0,0,8'hFF,4'hE,2},
    '{IC_EXTENDED, 0,0,0,0,0,0,0,0,1,8'hFF,4'h1,3},
    '{IC_EXTENDED, 0,0,1,0,0,0,0,0,0,8'hFF,4'hE,2},
    '{IC_HALT,     0,0,1,1,0,0,0,0,1,8'hFF,4'h7,2},
    '{IC_HALT,     0,0,1,0,0,0,0,0,0,8'hFF,4'hE,2},
    '{IC_DIVIDE,   0,0,1,0,0,1,0,0,1,8'h00,4'h0,2},
    '{IC_DIVIDE,   0,0,1,0,0,0,1,0,1,8'h00,4'h0,2},
    '{IC_PLAIN,    0,0,1,0,1,0,0,0,1,8'hFF,4'h6,1},
    '{IC_BYTE_LOAD,0,0,1,0,0,0,0,0,0,8'hFF,4'hE,2},
    '{IC_WORD_LOAD,0,0,1,0,0,0,0,0,0,8'hFF,4'hE,2},
    '{IC_EX_AF,    0,0,1,0,0,0,0,0,0,8'hFF,4'hE,2},
    '{IC_PUSH,     0,0,1,0,0,0,0,3,1,8'hFF,4'h5,2},
    '{IC_PUSH,     0,0,1,0,0,0,0,3,0,8'h00,4'hE,2},
    // masked step stays pending, so it must come after all unmasked rows
    '{IC_PLAIN,    0,0,1,0,1,0,0,0,0,8'h00,4'hE,2}};

  ctic_trap_ctrl u_dut (.i_mclk, .i_reset, .i_instr_start, .i_instr_class,
    .i_instr_addr, .i_next_addr, .i_privileged, .i_iter_done, .i_block_last,
    .i_instr_done, .i_div_zero, .i_div_ovf, .i_ext_src_addr, .i_ext_dst_addr,
    .i_push_valid, .i_sp_after_push, .i_user_xfer_ok, .i_mmu_violation,
    .i_mmu_fault_addr, .i_user_mode, .i_ext_arch_enable, .i_single_step,
    .i_bp_on_halt, .i_stack_limit, .i_msr, .i_trap_mask, .i_irq,
    .i_irq_enable, .o_hold_instr, .o_abort, .o_commit, .o_push_valid,
    .o_push_data, .o_vector_take, .o_vector_cause, .o_vector_mode,
    .o_enter_system, .o_fault_page, .o_flag_write, .o_flag_ok,
    .o_trap_pending);
  ctic_periph u_irq (.i_mclk, .i_reset, .i_raise(raise),
    .i_ack(o_vector_take && o_vector_cause == 4'hF), .o_irq(i_irq));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge i_mclk);
    #1;
  endtask
  task automatic final_report();
    if (err_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // issues one instruction; 4'hE means no vector within the bound
  task automatic run(input ctic_iclass_t c, input logic [1:0] ev,
                     output logic [3:0] cause, output logic [15:0] p0, p1);
    int k;
    int n;
    cause = 4'hE;
    n = 0;
    i_instr_class = c;
    i_instr_start = 1'b1;
    tick();
    i_instr_start = 1'b0;
    for (k = 0; k < 30 && cause === 4'hE; k++)
    begin
      i_instr_done = (ev == 2'h0 || ev == 2'h3) && k == 1;
      i_iter_done = ev == 2'h1 && k == 1;
      i_mmu_violation = ev == 2'h2 && k == 1;
      i_push_valid = ev == 2'h3 && k == 0;
      #1;
      if (o_push_valid && n == 0) p0 = o_push_data;
      if (o_push_valid && n == 1) p1 = o_push_data;
      n += int'(o_push_valid);
      if (o_vector_take) cause = o_vector_cause;
      tick();
    end
    {i_instr_done, i_iter_done, i_mmu_violation, i_push_valid} = '0;
    tick();
  endtask

  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  initial
  begin
    ctic_row_t r;
    logic [3:0] c;
    logic [15:0] p0, p1, rt;
    {i_instr_start, i_iter_done, i_block_last, i_instr_done, raise} = '0;
    {i_push_valid, i_mmu_violation, i_irq_enable} = '0;
    {i_user_mode, i_single_step, i_bp_on_halt, i_privileged} = '0;
    {i_div_zero, i_div_ovf, i_user_xfer_ok} = '0;
    i_ext_arch_enable = 1'b1;
    i_instr_class = IC_PLAIN;
    {i_instr_addr, i_next_addr, i_ext_src_addr, i_ext_dst_addr} = '0;
    {i_msr, i_mmu_fault_addr} = {16'h0000, 16'h9ABC};
    {i_stack_limit, i_sp_after_push} = {16'h8000, 16'h8006};
    i_trap_mask = 8'hFF;
    i_reset = 1'b1;
    repeat (6) @(posedge i_mclk);
    #1 i_reset = 1'b0;
    tick();
    for (int i = 0; i < 17; i++)
    begin
      r = rows[i];
      i_instr_addr = 16'h4000 + 16'(i * 4);
      i_next_addr = i_instr_addr + 16'h0002;
      i_ext_dst_addr = i_instr_addr + 16'h0100;
      i_ext_src_addr = i_instr_addr + 16'h0200;
      i_msr = {8'hA5, 8'(i)};
      i_user_xfer_ok = i[0];
      {i_privileged, i_user_mode, i_ext_arch_enable} = {r.pv, r.um, r.ext};
      {i_bp_on_halt, i_single_step, i_div_zero, i_div_ovf} =
        {r.bp, r.ss, r.dz, r.ov};
      i_trap_mask = r.msk;
      run(r.cls, r.ev, c, p0, p1);
      rt = r.rs == 2'h0 ? i_instr_addr : r.rs == 2'h1 ? i_next_addr
         : i_ext_dst_addr;
      check(16'(c), 16'(r.cause));
      if (r.vec)
        check(p0, i_msr);
      if (r.vec && r.rs != 2'h2)
        check(p1, rt);
      if (r.vec && c === 4'hE)
      begin
        err_count++;
        final_report();
      end
    end
    check(16'(o_trap_pending[TR_STKW]), 16'h0001);
    {i_single_step, i_div_zero, i_div_ovf, i_user_mode} = '0;
    i_irq_enable = 1'b1;
    for (int j = 0; j < 2; j++)
    begin
      raise = 1'b1;
      tick();
      raise = 1'b0;
      repeat (3) tick();
      i_instr_addr = 16'h6000 + 16'(j * 8);
      i_next_addr = i_instr_addr + 16'h0003;
      run(j ? IC_BLOCK : IC_PLAIN, 2'(j), c, p0, p1);
      check(16'(c), 16'h000F);
      check(p1, j ? i_instr_addr : i_next_addr);
    end
    i_irq_enable = 1'b0;
    run(IC_PLAIN, 2'h2, c, p0, p1);
    check(16'(c), 16'h0004);
    check(p1, i_instr_addr);
    check(o_fault_page, 16'h9ABC);
    i_reset = 1'b1;
    tick();
    check(16'(o_trap_pending), 16'h0000);
    check(16'(o_vector_mode), 16'h0003);
    check(16'(o_hold_instr), 16'h0000);
    i_reset = 1'b0;
    tick();
    final_report();
  end
endmodule // tb_top
